// *** hdl/rfa_field_cell.sv ***
`default_nettype none
`include "rfa_cfg.svh"
// one field of a chosen access kind
module rfa_field_cell
  import rfa_pkg::*;
#(
  parameter rfa_kind_t KIND = RFA_RW,
  parameter int WIDTH = `RFA_DEF_WIDTH,
  parameter logic [WIDTH-1:0] RST_VAL = '0,
  parameter bit SR_EXEMPT = 1'b0,
  parameter bit STICKY = 1'b0
) (
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  input wire logic soft_rst_i,
  input wire logic hot_rst_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [WIDTH-1:0] wdata_i,
  input wire logic [WIDTH-1:0] hw_set_i,
  input wire logic [WIDTH-1:0] hw_clr_i,
  output logic [WIDTH-1:0] rdata_o,
  output logic [WIDTH-1:0] value_o
);
  logic [WIDTH-1:0] val_r;
  logic [WIDTH-1:0] val_nxt;
  logic [WIDTH-1:0] sw_q;
  logic [WIDTH-1:0] hw_q;

  // elaboration-time refusal of widths the package structs cannot carry
  if (WIDTH < 1 || WIDTH > `RFA_DEF_WIDTH) begin : g_bad_width
    $error("rfa_field_cell: bad width");
  end

  // software side first, hardware events applied last so they win
  always_comb begin
    sw_q = val_r;
    hw_q = '0;
    case (KIND)
      RFA_RW, RFA_WO: if (wr_i) sw_q = wdata_i;
      RFA_RO: sw_q = hw_set_i;
      RFA_W1S: if (wr_i) sw_q = val_r | wdata_i;
      RFA_W1C: if (wr_i) sw_q = val_r & ~wdata_i;
      RFA_CLR_ANY_WR, RFA_RWAC: if (wr_i) sw_q = '0;
      RFA_RC, RFA_LATCH_HI: if (rd_i) sw_q = '0;
      RFA_LATCH_LO: if (rd_i) sw_q = '1;
      RFA_ROLH: if (rd_i) sw_q = hw_set_i;
      RFA_SELF_CLR: sw_q = (wr_i ? (val_r | wdata_i) : val_r) & ~hw_clr_i;
      RFA_SS: sw_q = (wr_i ? (val_r & wdata_i) : val_r) | hw_set_i;
      default: sw_q = val_r;
    endcase
    // set wins over the read or write clear
    case (KIND)
      RFA_W1C, RFA_CLR_ANY_WR, RFA_RWAC, RFA_RC, RFA_LATCH_HI, RFA_ROLH: hw_q = hw_set_i;
      default: hw_q = '0;
    endcase
    val_nxt = sw_q | hw_q;
    // low latch: a low cause wins over release by read
    if (KIND == RFA_LATCH_LO) val_nxt = sw_q & ~hw_clr_i;
  end

  // software reset spares exempt fields, hot reset spares sticky ones
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      val_r <= RST_VAL;
    end else if (hot_rst_i && !STICKY) begin
      val_r <= RST_VAL;
    end else if (soft_rst_i && !SR_EXEMPT && !STICKY) begin
      val_r <= RST_VAL;
    end else begin
      val_r <= val_nxt;
    end
  end

  // write-only reads back zero; reads are undefined to software anyway
  assign rdata_o = (KIND == RFA_WO) ? '0 : val_r;
  assign value_o = val_r;

  ro_nowrite_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    (KIND == RFA_RO && !hot_rst_i && !soft_rst_i) |=> val_r == $past(hw_set_i))
    else $error("read-only field took wrong value");
  w1c_clear_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    (KIND == RFA_W1C && wr_i && !hot_rst_i && !soft_rst_i)
      |=> val_r == (($past(val_r) & ~$past(wdata_i)) | $past(hw_set_i)))
    else $error("write-one-clear wrong");
  lh_hold_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    (KIND == RFA_LATCH_HI && !rd_i && !hot_rst_i && !soft_rst_i) |=> (val_r & $past(val_r)) == $past(val_r))
    else $error("latched high bit dropped without read");
  wac_clear_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    (KIND == RFA_CLR_ANY_WR && wr_i && hw_set_i == '0 && !hot_rst_i) |=> val_r == '0)
    else $error("clear on write failed");
  rc_clear_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    (KIND == RFA_RC && rd_i && hw_set_i == '0 && !hot_rst_i) |=> val_r == '0)
    else $error("clear on read failed");
  sticky_keep_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    (STICKY && (hot_rst_i || soft_rst_i)) |=> val_r == $past(val_nxt))
    else $error("sticky field altered by reset");
  exempt_keep_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    (SR_EXEMPT && soft_rst_i && !hot_rst_i) |=> val_r == $past(val_nxt))
    else $error("exempt field altered by soft reset");
  set_wins_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    (KIND == RFA_W1C && wr_i && !hot_rst_i && !soft_rst_i) |=> (val_r & $past(hw_set_i)) == $past(hw_set_i))
    else $error("event lost on same cycle clear");
  rw_store_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    (KIND == RFA_RW && wr_i && !hot_rst_i && !soft_rst_i) |=> rdata_o == $past(wdata_i))
    else $error("read-write field did not store");
endmodule
`default_nettype wire

// *** hdl/rfa_cfg.svh ***
`ifndef RFA_CFG_SVH
`define RFA_CFG_SVH
// access kind encodings of a field cell
`define RFA_K_RW 4'h0
`define RFA_K_RO 4'h1
`define RFA_K_WO 4'h2
`define RFA_K_W1S 4'h3
`define RFA_K_W1C 4'h4
`define RFA_K_CLR_ANY_WR 4'h5
`define RFA_K_RC 4'h6
`define RFA_K_LATCH_LO 4'h7
`define RFA_K_LATCH_HI 4'h8
`define RFA_K_SELF_CLR 4'h9
`define RFA_K_SS 4'ha
`define RFA_K_ROLH 4'hb
`define RFA_K_RWAC 4'hc
// default field width and cell count
`define RFA_DEF_WIDTH 16
`define RFA_DEF_CELLS 13
`endif

// *** hdl/rfa_pkg.sv ***
`default_nettype none
`include "rfa_cfg.svh"
package rfa_pkg;
  typedef enum logic [3:0] {
    RFA_RW = `RFA_K_RW, RFA_RO = `RFA_K_RO, RFA_WO = `RFA_K_WO, RFA_W1S = `RFA_K_W1S,
    RFA_W1C = `RFA_K_W1C, RFA_CLR_ANY_WR = `RFA_K_CLR_ANY_WR, RFA_RC = `RFA_K_RC,
    RFA_LATCH_LO = `RFA_K_LATCH_LO, RFA_LATCH_HI = `RFA_K_LATCH_HI, RFA_SELF_CLR = `RFA_K_SELF_CLR,
    RFA_SS = `RFA_K_SS, RFA_ROLH = `RFA_K_ROLH, RFA_RWAC = `RFA_K_RWAC
  } rfa_kind_t;
  // one register access from management software
  typedef struct packed {
    logic wr;
    logic rd;
    logic [`RFA_DEF_WIDTH-1:0] wdata;
  } rfa_acc_t;
  // hardware side of one cell
  typedef struct packed {
    logic [`RFA_DEF_WIDTH-1:0] set;
    logic [`RFA_DEF_WIDTH-1:0] clr;
  } rfa_hw_t;
endpackage
`default_nettype wire

// *** hdl/rfa_field_bank.sv ***
`default_nettype none
`include "rfa_cfg.svh"
// Notes on behaviour
// - read-only returns its value, writes are ignored
// - write-only stores writes, reads are undefined (zero here)
// - write one sets a bit, zero leaves it
// - write one clears a bit, zero leaves it
// - any write clears the field regardless of data
// - read returns contents then clears them; writes ignored
// - low latch holds captured low until register read
// - high latch holds captured high until register read
// - self-clearing bit returns to zero itself; writing zero does nothing
// - self-setting bit returns to one itself; writing one does nothing
// - latched-high status rises on cause, holds until read
// - after read it follows its cause
// - soft reset exempt fields keep value on software reset
// - persistent fields untouched by hot or function-level reset
// - read-write stores writes, reads return last stored value
// - readable clear-on-write returns value, any write clears it
module rfa_field_bank
  import rfa_pkg::*;
#(
  parameter int WIDTH = `RFA_DEF_WIDTH
) (
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  input wire logic soft_rst_i,
  input wire logic hot_rst_i,
  input wire logic [`RFA_DEF_CELLS-1:0] sel_i,
  input wire rfa_acc_t acc_i,
  input wire rfa_hw_t [`RFA_DEF_CELLS-1:0] hw_i,
  output logic [WIDTH-1:0] rdata_o,
  output logic [`RFA_DEF_CELLS-1:0][WIDTH-1:0] value_o
);
  localparam rfa_kind_t KINDS [`RFA_DEF_CELLS] = '{RFA_RW, RFA_RO, RFA_WO, RFA_W1S, RFA_W1C,
    RFA_CLR_ANY_WR, RFA_RC, RFA_LATCH_LO, RFA_LATCH_HI, RFA_SELF_CLR, RFA_SS, RFA_ROLH, RFA_RWAC};
  logic [`RFA_DEF_CELLS-1:0][WIDTH-1:0] cell_rd;
  logic [WIDTH-1:0] rdata_r;

  // elaboration-time refusal: the access struct is fixed at the package width
  if (WIDTH != `RFA_DEF_WIDTH) begin : g_bad_width
    $error("rfa_field_bank: width must match package");
  end

  // one cell per access kind; the low-latch cell resets high, self-set too
  for (genvar g = 0; g < `RFA_DEF_CELLS; g++) begin : g_cell
    rfa_field_cell #(
      .KIND(KINDS[g]),
      .WIDTH(WIDTH),
      .RST_VAL((KINDS[g] == RFA_LATCH_LO || KINDS[g] == RFA_SS) ? '1 : '0),
      .SR_EXEMPT(KINDS[g] == RFA_RW),
      .STICKY(KINDS[g] == RFA_W1C)
    ) u_cell (
      .clk_sys_i(clk_sys_i),
      .rstn_i(rstn_i),
      .soft_rst_i(soft_rst_i),
      .hot_rst_i(hot_rst_i),
      .wr_i(acc_i.wr && sel_i[g]),
      .rd_i(acc_i.rd && sel_i[g]),
      .wdata_i(acc_i.wdata),
      .hw_set_i(hw_i[g].set),
      .hw_clr_i(hw_i[g].clr),
      .rdata_o(cell_rd[g]),
      .value_o(value_o[g])
    );
  end

  // read data captured on the read strobe: the value before any clear
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rdata_r <= '0;
    end else if (acc_i.rd) begin
      rdata_r <= '0;
      for (int i = 0; i < `RFA_DEF_CELLS; i++) begin
        if (sel_i[i]) rdata_r <= cell_rd[i];
      end
    end
  end
  assign rdata_o = rdata_r;

  cov_rd_c: cover property (@(posedge clk_sys_i) disable iff (!rstn_i) acc_i.rd && sel_i[6]);
  cov_wr_c: cover property (@(posedge clk_sys_i) disable iff (!rstn_i) acc_i.wr && sel_i[4]);
  cov_race_c: cover property (@(posedge clk_sys_i) disable iff (!rstn_i) acc_i.rd && sel_i[8] && |hw_i[8].set);
endmodule
`default_nettype wire

// *** testbench/register_field_access_semantics_tb.sv ***
`default_nettype none
module register_field_access_semantics_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import rfa_pkg::*;
  logic clk_sys_i = 0, rstn_i = 0, soft_rst_i = 0, hot_rst_i = 0;
  logic [12:0] sel_i = '0;
  rfa_acc_t acc_i = '0;
  rfa_hw_t [12:0] hw_i = '0;
  logic [15:0] rdata_o, m_rd, lf = 16'h005e;
  logic [12:0][15:0] value_o;
  logic [15:0] m [13];
  int error_cnt = 0, n_tests = 0;
  rfa_field_bank #(.WIDTH(16)) i_rfa_field_bank (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .soft_rst_i(soft_rst_i),
    .hot_rst_i(hot_rst_i), .sel_i(sel_i), .acc_i(acc_i), .hw_i(hw_i), .rdata_o(rdata_o), .value_o(value_o));
  initial forever #2 clk_sys_i = ~clk_sys_i;
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // reference model: integer-style update of every cell from the inputs sampled at the edge
  always @(posedge clk_sys_i or negedge rstn_i) begin
    logic w, r;
    logic [15:0] d, s, c;
    if (!rstn_i) begin
      foreach (m[k]) m[k] = (k == 7 || k == 10) ? 16'hffff : 16'h0000;
      m_rd = 16'h0000;
    end else if (soft_rst_i || hot_rst_i) begin
      // the sticky cell keeps its value; the exempt cell keeps it on soft reset only
      foreach (m[k]) if (k != 4 && !(k == 0 && !hot_rst_i)) m[k] = (k == 7 || k == 10) ? 16'hffff : 16'h0000;
    end else begin
      foreach (m[k]) begin
        w = acc_i.wr & sel_i[k];
        r = acc_i.rd & sel_i[k];
        d = acc_i.wdata;
        s = hw_i[k].set;
        c = hw_i[k].clr;
        if (r) m_rd = (k == 2) ? 16'h0000 : m[k];
        case (k)
          0, 2: if (w) m[k] = d;
          1: m[k] = s;
          3: if (w) m[k] = m[k] | d;
          4: m[k] = (w ? m[k] & ~d : m[k]) | s;
          5, 12: m[k] = (w ? 16'h0000 : m[k]) | s;
          6, 8: m[k] = (r ? 16'h0000 : m[k]) | s;
          7: m[k] = (r ? 16'hffff : m[k]) & ~c;
          9: m[k] = (w ? m[k] | d : m[k]) & ~c;
          10: m[k] = (w ? m[k] & d : m[k]) | s;
          default: m[k] = r ? s : m[k] | s;
        endcase
      end
    end
  end
  task automatic chk_val(input int k, input logic [15:0] e, input logic [15:0] g);
    n_tests++;
    if (g !== e) begin
      error_cnt++;
      $display("mismatch value_o[%0d] expected %h seen %h", k, e, g);
    end
  endtask
  task automatic chk_rd(input logic [15:0] e, input logic [15:0] g);
    n_tests++;
    if (g !== e) begin
      error_cnt++;
      $display("mismatch rdata_o expected %h seen %h", e, g);
    end
  endtask
  // compare mid-cycle, well away from the launching edge
  always @(negedge clk_sys_i) if (rstn_i) begin
    foreach (m[k]) chk_val(k, m[k], value_o[k]);
    chk_rd(m_rd, rdata_o);
  end
  // no cell holds reserved bits, so every write word is legal data
  task automatic drive(input int k, input logic w, input logic r, input logic [15:0] d, input rfa_hw_t [12:0] h);
    @(posedge clk_sys_i);
    sel_i <= 13'h1 << k;
    acc_i <= '{wr: w, rd: r, wdata: d};
    hw_i <= h;
  endtask
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    int k;
    logic rs, hs;
    rfa_hw_t [12:0] h;
    repeat (4) @(posedge clk_sys_i);
    rstn_i <= 1'b1;
    // every kind written with ones and read back once, then a pattern read back twice
    for (int i = 0; i < 13; i++) begin
      drive(i, 1, 0, 16'hffff, '0);
      drive(i, 0, 1, 16'h0000, '0);
      drive(i, 1, 0, 16'h0f0f, '0);
      drive(i, 0, 1, 16'h0000, '0);
      drive(i, 0, 1, 16'h0000, '0);
    end
    $display("test directed done");
    // random traffic with sparse hardware events and software/hot resets
    for (int i = 1; i <= 3000; i++) begin
      lf = lfsr(lf);
      k = lf % 13;
      rs = (i % 500 == 250);
      hs = (i % 700 == 350);
      foreach (h[j]) begin
        lf = lfsr(lf);
        h[j].set = (j inside {0, 2, 3, 7, 9}) ? 16'h0000 : lf & lfsr(lf);
        h[j].clr = (j inside {7, 9}) ? lf & lfsr(lf) : 16'h0000;
      end
      // concurrent write and self-clear or self-set order is left open
      if (lf[4] && k == 9) h[9].clr = 16'h0000;
      if (lf[4] && k == 10) h[10].set = 16'h0000;
      if (rs || hs) h = '0;
      drive(k, lf[4] & !(rs | hs), lf[5] & !(rs | hs), lfsr(lf), h);
      soft_rst_i <= rs;
      hot_rst_i <= hs;
    end
    $display("test random done");
    drive(0, 0, 0, 16'h0000, '0);
    rstn_i <= 1'b0;
    repeat (4) @(posedge clk_sys_i);
    rstn_i <= 1'b1;
    repeat (3) @(posedge clk_sys_i);
    $display("test mid-run reset done");
    summarize();
  end
  // watchdog: about 3100 cycles expected
  initial begin
    repeat (6000) @(posedge clk_sys_i);
    error_cnt++;
    summarize();
  end
endmodule
`default_nettype wire
